// File: scs_card_model.sv
// Behavioural smart card on the pulled-up shared data line
module scs_card_model #(
	parameter int ETU = 744
) (
	// Clock
	input  wire logic       clk,
	// Shared data line
	input  wire logic       line,
	output logic            drive,
	// Bench commands
	input  wire logic       tx_go,
	input  wire logic [8:0] tx_bits,
	input  wire logic       nak,
	// Observations
	output logic            done,
	output logic [8:0]      got,
	output logic            err_seen,
	output int              gap
);
	timeunit 1ns;
	timeprecision 1ps;

	int   now  = 0;
	int   last = 0;
	logic nak_q;

	always @(posedge clk) now <= now + 1;

	// ========================================
	// Frame engine
	initial begin
		drive = 1'b0;
		done = 1'b0;
		got = 9'h000;
		err_seen = 1'b0;
		gap = 0;
		forever begin
			@(posedge clk);
			if (tx_go) begin
				drive <= 1'b1;
				repeat (ETU) @(posedge clk);
				for (int i = 0; i < 9; i++) begin
					drive <= !tx_bits[i];
					repeat (ETU) @(posedge clk);
				end
				drive <= 1'b0;
				repeat (ETU) @(posedge clk);
				err_seen <= !line;
				repeat (2 * ETU) @(posedge clk);
			end else if (line === 1'b0) begin
				gap = now - last;
				last = now;
				nak_q = nak;
				repeat (ETU / 2) @(posedge clk);
				for (int i = 0; i < 9; i++) begin
					repeat (ETU) @(posedge clk);
					got[i] <= line;
				end
				repeat (ETU) @(posedge clk);
				if (nak_q) begin
					drive <= 1'b1;
					repeat (ETU) @(posedge clk);
					drive <= 1'b0;
				end
				done <= 1'b1;
				@(posedge clk);
				done <= 1'b0;
			end
		end
	end
endmodule : scs_card_model

// File: scs_pkg.sv
// Constants, register map and state encoding of the smart card serial interface
// Operation
// RULE1: Start bit, eight data bits, parity; async only
// RULE2: Transmit guard of at least two etu
// RULE3: Parity error: drive low 1 etu at 10.5
// RULE4: Sampled error pulse resends same character later
// RULE5: One shared open-drain line, released after parity
// RULE6: Card checks parity, answers with error pulse; the card model does not check parity and pulses only when the bench sets nak
// RULE7: Both enables set allow loop-back self test
// RULE8: Software keeps fixed mode and control bits
// RULE9: Standard mode: clock off or running
// RULE10: Gsm mode: clock running, fixed high or low
// RULE11: Software selects convention and enables card mode
// RULE12: Direct convention: high is one, lsb first
// RULE13: Inverse convention: low is one, msb first
// RULE14: Inversion touches data bits only, never parity
// RULE15: Bit clock only from internal rate generator
// RULE16: Clock pin runs at 372 times bit rate
// RULE17: Bit period 1488 * 2^(2n-1) * (N+1) clocks
// RULE18: Gsm mode: 00 low, 10 high, lo bit runs
// RULE19: Error flag set on low pulse, read-then-write clears
// RULE20: End flag at 12.5 etu, gsm at 11.0
// RULE21: Mid-bit sampling timed from detected start edge
// RULE22: Resend until clean frame, then take next
package scs_pkg;

	// ========================================
	// Clock
	localparam int          CLK_PERIOD_NS = 4;

	// ========================================
	// Register indices (byte address is four times the index)
	localparam logic [15:0] IDX_MODE      = 16'hffb0;
	localparam logic [15:0] IDX_DIV       = 16'hffb1;
	localparam logic [15:0] IDX_CTRL      = 16'hffb2;
	localparam logic [15:0] IDX_TXBUF     = 16'hffb3;
	localparam logic [15:0] IDX_STATUS    = 16'hffb4;
	localparam logic [15:0] IDX_RXBUF     = 16'hffb5;
	localparam logic [15:0] IDX_CARD      = 16'hffb6;

	// Internal register selects
	localparam logic [2:0]  RSEL_MODE     = 3'h0;
	localparam logic [2:0]  RSEL_DIV      = 3'h1;
	localparam logic [2:0]  RSEL_CTRL     = 3'h2;
	localparam logic [2:0]  RSEL_TXBUF    = 3'h3;
	localparam logic [2:0]  RSEL_STATUS   = 3'h4;
	localparam logic [2:0]  RSEL_RXBUF    = 3'h5;
	localparam logic [2:0]  RSEL_CARD     = 3'h6;
	localparam logic [2:0]  RSEL_NONE     = 3'h7;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;

	// ========================================
	// Field positions
	localparam int          MODE_GSM      = 7;
	localparam int          MODE_ODD      = 4;
	localparam int          MODE_PS_HI    = 1;
	localparam int          MODE_PS_LO    = 0;
	localparam int          CTRL_TX_EN    = 5;
	localparam int          CTRL_RX_EN    = 4;
	localparam int          CTRL_CLK_HI   = 1;
	localparam int          CTRL_CLK_LO   = 0;
	localparam int          STS_TXE       = 7;
	localparam int          STS_RXF       = 6;
	localparam int          STS_OVR       = 5;
	localparam int          STS_ERRSIG    = 4;
	localparam int          STS_PAR       = 3;
	localparam int          STS_TXEND     = 2;
	localparam int          CARD_DIR      = 3;
	localparam int          CARD_INV      = 2;
	localparam int          CARD_EN       = 0;

	// ========================================
	// Masks and reset values
	localparam logic [7:0]  CARD_MASK     = 8'h0d;
	localparam logic [7:0]  STS_CLR_MASK  = 8'hf8;
	localparam logic [7:0]  RST_STATUS    = 8'h84;
	localparam logic [7:0]  RST_REG       = 8'h00;

	// ========================================
	// Frame timing, in half etu steps from start edge
	localparam int          SCK_PER_ETU   = 372;
	localparam logic [8:0]  SUB_LAST      = 9'(SCK_PER_ETU - 1);
	localparam logic [4:0]  P_DELIVER     = 5'd19;
	localparam logic [4:0]  P_RELEASE     = 5'd20;
	localparam logic [4:0]  P_ERR_SAMPLE  = 5'd21;
	localparam logic [4:0]  P_PULSE_A     = 5'd21;
	localparam logic [4:0]  P_PULSE_B     = 5'd22;
	localparam logic [4:0]  P_TRANSMIT_END_FLAG_GSM    = 5'd21;
	localparam logic [4:0]  P_TRANSMIT_END_FLAG_STD    = 5'd24;
	localparam logic [4:0]  P_RX_END      = 5'd23;
	localparam logic [4:0]  P_END         = 5'd24;
	localparam logic [4:0]  P_END_RETRY   = 5'd27;

	// ========================================
	// Frame engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TX   = 3'b010,
		ST_RX   = 3'b100
	} scs_state_t;

endpackage : scs_pkg

// File: scs_tb_top.sv
// Self-checking bench of the smart card serial interface
module scs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int ETU = 744;
	logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        nak = 1'b0, tx_go = 1'b0, rd_ph = 1'b0, prev;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, out_oe, out_pin, sck, sck_oe, drive, done, err_seen, line;
	logic [8:0]  tx_bits = 9'h0, got;
	logic [7:0]  lfsr = 8'h2f, b;
	int          gap, cnt, olen = 0, plen = 0, num_errors = 0, n_checks = 0;
	logic [31:0] rdq[$];
	logic [8:0]  cq[$];
	logic [7:0]  ndiv[3] = '{8'h00, 8'h02, 8'h00};
	logic [1:0]  nsel[3] = '{2'h0, 2'h0, 2'h1};
	int          win[3] = '{744, 2232, 2976};
	logic [7:0]  fm[3] = '{8'ha8, 8'ha8, 8'h28};
	logic [7:0]  fc[3] = '{8'h00, 8'h02, 8'h00};
	logic [1:0]  fx[3] = '{2'h2, 2'h3, 2'h0};

	always #2 clk = ~clk;
	assign line = !((out_oe & !out_pin) | drive);

	scs_top uut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(line), .serial_out_pin(out_pin),
		.serial_out_oe(out_oe), .serial_clock_pin(sck), .serial_clock_oe(sck_oe));
	scs_card_model #(.ETU(ETU)) card (.clk(clk), .line(line), .drive(drive), .tx_go(tx_go),
		.tx_bits(tx_bits), .nak(nak), .done(done), .got(got), .err_seen(err_seen), .gap(gap));

	// ========================================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next

	function automatic logic [8:0] line_bits(input logic [7:0] d, input logic inv);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = inv ? ~d[7 - i] : d[i];
		return {^r ^ inv, r};
	endfunction : line_bits

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {14'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		if (!wr) rdq.push_back({24'h0, d});
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask : bus

	task automatic wait_for(input logic low);
		int k;
		k = 0;
		while ((low ? line !== 1'b0 : cq.size() != 0) && k < 40000) begin
			@(posedge clk);
			k++;
		end
		if (k == 40000) num_errors++;
	endtask : wait_for

	task automatic tx_byte(input logic [7:0] d, input logic inv, input int t0, input int t1,
		input logic [7:0] xs);
		cq.push_back(line_bits(d, inv));
		bus(1'b1, scs_pkg::IDX_TXBUF, d);
		bus(1'b0, scs_pkg::IDX_STATUS, 8'h84);
		bus(1'b1, scs_pkg::IDX_STATUS, 8'h7f);
		wait_for(1'b1);
		cyc(t0 * ETU / 2);
		bus(1'b0, scs_pkg::IDX_STATUS, xs);
		cyc((t1 - t0) * ETU / 2 - 2);
		bus(1'b0, scs_pkg::IDX_STATUS, xs | 8'h84);
	endtask : tx_byte

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict

	// ========================================
	// Result monitor
	always @(posedge clk) begin
		if (rd_ph && hreadyout === 1'b1) begin
			check(hrdata, rdq.pop_front());
			check({31'h0, hresp}, 32'h0);
		end
		rd_ph <= hsel & htrans[1] & hreadyout & !hwrite;
		if (done === 1'b1) check({23'h0, got}, {23'h0, cq.pop_front()});
		if (out_oe === 1'b1) olen <= olen + 1;
		else begin
			olen <= 0;
			if (olen > 0) plen <= olen;
		end
	end

	initial begin
		cyc(96000);
		num_errors++;
		print_verdict();
	end

	// ========================================
	// Tests
	initial begin
		cyc(5);
		rstn <= 1'b1;
		cyc(1);
		bus(1'b0, scs_pkg::IDX_STATUS, 8'h84);
		bus(1'b0, scs_pkg::IDX_MODE, 8'h00);
		bus(1'b0, 16'hffb7, 8'h00);
		bus(1'b1, scs_pkg::IDX_CARD, 8'hff);
		bus(1'b0, scs_pkg::IDX_CARD, 8'h0d);
		bus(1'b1, scs_pkg::IDX_DIV, 8'ha5);
		hsize <= 3'h0;
		bus(1'b1, scs_pkg::IDX_DIV, 8'h3c);
		hsize <= 3'h2;
		bus(1'b0, scs_pkg::IDX_DIV, 8'ha5);
		bus(1'b1, scs_pkg::IDX_RXBUF, 8'hff);
		bus(1'b0, scs_pkg::IDX_RXBUF, 8'h00);
		$display("registers done");
		bus(1'b1, scs_pkg::IDX_CARD, 8'h01);
		bus(1'b1, scs_pkg::IDX_CTRL, 8'h01);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, scs_pkg::IDX_MODE, {6'h0a, nsel[i]});
			bus(1'b1, scs_pkg::IDX_DIV, ndiv[i]);
			cyc(1100);
			cnt = 0;
			prev = sck;
			repeat (win[i]) begin
				@(posedge clk);
				if (sck && !prev) cnt++;
				prev = sck;
			end
			check(cnt, 32'd372);
		end
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, scs_pkg::IDX_MODE, fm[i]);
			bus(1'b1, scs_pkg::IDX_CTRL, fc[i]);
			cyc(8);
			check({30'h0, sck_oe, sck_oe & sck}, {30'h0, fx[i]});
		end
		$display("clock pin done");
		bus(1'b1, scs_pkg::IDX_MODE, 8'h28);
		bus(1'b1, scs_pkg::IDX_DIV, 8'h00);
		bus(1'b1, scs_pkg::IDX_CTRL, 8'h20);
		cyc(1100);
		b = lfsr;
		lfsr = lfsr_next(lfsr);
		tx_byte(b, 1'b0, 24, 26, 8'h00);
		$display("direct transmit done");
		cq.push_back(line_bits(8'h3b, 1'b0));
		cq.push_back(line_bits(8'h3b, 1'b0));
		nak <= 1'b1;
		bus(1'b1, scs_pkg::IDX_TXBUF, 8'h3b);
		bus(1'b0, scs_pkg::IDX_STATUS, 8'h84);
		bus(1'b1, scs_pkg::IDX_STATUS, 8'h7f);
		wait_for(1'b1);
		cyc(4);
		nak <= 1'b0;
		wait_for(1'b0);
		check({31'h0, gap >= 12 * ETU}, 32'h1);
		cyc(3 * ETU);
		bus(1'b1, scs_pkg::IDX_CTRL, 8'h00);
		bus(1'b0, scs_pkg::IDX_STATUS, 8'h94);
		bus(1'b1, scs_pkg::IDX_STATUS, 8'hef);
		bus(1'b0, scs_pkg::IDX_STATUS, 8'h84);
		$display("retransmit done");
		bus(1'b1, scs_pkg::IDX_MODE, 8'hb8);
		bus(1'b1, scs_pkg::IDX_CARD, 8'h0d);
		bus(1'b1, scs_pkg::IDX_CTRL, 8'h20);
		cyc(ETU);
		tx_byte(8'h3f, 1'b1, 21, 23, 8'h00);
		$display("inverse transmit done");
		bus(1'b1, scs_pkg::IDX_MODE, 8'h28);
		bus(1'b1, scs_pkg::IDX_CARD, 8'h01);
		bus(1'b1, scs_pkg::IDX_CTRL, 8'h10);
		cyc(ETU);
		tx_bits <= line_bits(8'h5a, 1'b0);
		tx_go <= 1'b1;
		cyc(1);
		tx_go <= 1'b0;
		cyc(14 * ETU);
		check({31'h0, err_seen}, 32'h0);
		bus(1'b0, scs_pkg::IDX_RXBUF, 8'h5a);
		bus(1'b0, scs_pkg::IDX_STATUS, 8'hc4);
		bus(1'b1, scs_pkg::IDX_STATUS, 8'hbf);
		$display("receive done");
		bus(1'b1, scs_pkg::IDX_CTRL, 8'h30);
		b = lfsr;
		lfsr = lfsr_next(lfsr);
		tx_byte(b, 1'b0, 24, 26, 8'h40);
		bus(1'b0, scs_pkg::IDX_RXBUF, b);
		bus(1'b1, scs_pkg::IDX_STATUS, 8'hbf);
		$display("loop-back done");
		bus(1'b1, scs_pkg::IDX_CTRL, 8'h10);
		cyc(ETU);
		tx_bits <= line_bits(8'ha7, 1'b0) ^ 9'h100;
		tx_go <= 1'b1;
		cyc(1);
		tx_go <= 1'b0;
		cyc(14 * ETU);
		check({31'h0, err_seen}, 32'h1);
		check(plen, ETU);
		bus(1'b0, scs_pkg::IDX_RXBUF, 8'ha7);
		$display("parity error done");
		print_verdict();
	end
endmodule : scs_tb_top

// File: scs_top.sv
// Smart card serial interface with AHB-Lite register slave
module scs_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Card data line
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	output logic             serial_out_oe,
	// Card clock
	output logic             serial_clock_pin,
	output logic             serial_clock_oe
);

	// ========================================
	// State
	typedef struct packed {
		scs_pkg::scs_state_t state;
		logic [14:0]         pre;
		logic [8:0]          sub;
		logic [4:0]          pos;
		logic                sck;
		logic                line_s1;
		logic                line_s2;
		logic                line_prev;
		logic [7:0]          mode;
		logic [7:0]          div;
		logic [7:0]          ctrl;
		logic [7:0]          txbuf;
		logic [7:0]          status;
		logic [7:0]          rxbuf;
		logic [7:0]          card;
		logic [7:0]          seen;
		logic [9:0]          txf;
		logic [9:0]          rxf;
		logic                err;
		logic                perr;
		logic                ap_valid;
		logic                ap_wr;
		logic [2:0]          ap_sel;
		logic [31:0]         hrdata;
		logic                hready;
		logic                hresp;
		logic                data_out;
		logic                data_oe;
		logic                sck_out;
		logic                sck_oe;
	} scs_regs_t;

	scs_regs_t   s;
	scs_regs_t   n;
	logic        tick;
	logic        hstep;
	logic [14:0] lim;
	logic        ap;
	logic [2:0]  sel;
	logic [7:0]  clr;
	logic [7:0]  lb;
	logic [7:0]  rdat;
	logic        bad;
	logic        err_now;
	logic        gsm;
	logic        en;
	logic        txen;
	logic        rxen;

	// ========================================
	// Functions
	function automatic logic [2:0] scs_decode(input logic [15:0] idx);
		logic [2:0] r;
		r = scs_pkg::RSEL_NONE;
		case (idx)
			scs_pkg::IDX_MODE:   r = scs_pkg::RSEL_MODE;
			scs_pkg::IDX_DIV:    r = scs_pkg::RSEL_DIV;
			scs_pkg::IDX_CTRL:   r = scs_pkg::RSEL_CTRL;
			scs_pkg::IDX_TXBUF:  r = scs_pkg::RSEL_TXBUF;
			scs_pkg::IDX_STATUS: r = scs_pkg::RSEL_STATUS;
			scs_pkg::IDX_RXBUF:  r = scs_pkg::RSEL_RXBUF;
			scs_pkg::IDX_CARD:   r = scs_pkg::RSEL_CARD;
			default:             r = scs_pkg::RSEL_NONE;
		endcase
		return r;
	endfunction : scs_decode

	// Convention mapping, same in both directions
	function automatic logic [7:0] scs_conv(input logic [7:0] v, input logic dir,
			input logic inv);
		logic [7:0] r;
		logic [7:0] o;
		r = v ^ {8{inv}}; // RULE14
		o = '0;
		for (int i = 0; i < 8; i++) begin
			o[i] = dir ? r[7 - i] : r[i]; // RULE12 RULE13
		end
		return o;
	endfunction : scs_conv

	// ========================================
	// Next state
	always_comb begin
		n = s;
		tick = 1'b0;
		hstep = 1'b0;
		gsm = s.mode[scs_pkg::MODE_GSM];
		en = s.card[scs_pkg::CARD_EN];
		txen = s.ctrl[scs_pkg::CTRL_TX_EN];
		rxen = s.ctrl[scs_pkg::CTRL_RX_EN];
		n.line_s1 = serial_in_pin;
		n.line_s2 = s.line_s1;
		n.line_prev = s.line_s2;

		// Rate generator: half clock period is 4^n * (N + 1) cycles
		lim = (({7'h00, s.div} + 15'h0001) << {s.mode[scs_pkg::MODE_PS_HI],
			s.mode[scs_pkg::MODE_PS_LO], 1'b0}) - 15'h0001; // RULE15 RULE17
		if (s.pre >= lim) begin
			n.pre = '0;
			tick = 1'b1;
		end else begin
			n.pre = s.pre + 15'h0001;
		end
		if (tick) begin
			n.sck = ~s.sck; // RULE16
			if (s.sub == scs_pkg::SUB_LAST) begin
				n.sub = '0;
				hstep = 1'b1; // RULE17
			end else begin
				n.sub = s.sub + 9'h001;
			end
		end

		// Bus address phase
		ap = hsel && hready && htrans[1];
		sel = scs_decode(haddr[17:2]);
		n.ap_valid = ap;
		n.ap_wr = hwrite && (hsize == scs_pkg::HSIZE_WORD);
		n.ap_sel = sel;
		n.hready = 1'b1;
		n.hresp = 1'b0;
		n.hrdata = '0;
		if (ap && !hwrite) begin
			case (sel)
				scs_pkg::RSEL_MODE:   n.hrdata = {24'h000000, s.mode};
				scs_pkg::RSEL_DIV:    n.hrdata = {24'h000000, s.div};
				scs_pkg::RSEL_CTRL:   n.hrdata = {24'h000000, s.ctrl};
				scs_pkg::RSEL_TXBUF:  n.hrdata = {24'h000000, s.txbuf};
				scs_pkg::RSEL_STATUS: n.hrdata = {24'h000000, s.status};
				scs_pkg::RSEL_RXBUF:  n.hrdata = {24'h000000, s.rxbuf};
				scs_pkg::RSEL_CARD:   n.hrdata = {24'h000000, s.card};
				default:              n.hrdata = '0;
			endcase
			if (sel == scs_pkg::RSEL_STATUS) begin
				n.seen = s.status & scs_pkg::STS_CLR_MASK;
			end
		end

		// Bus data phase writes, before hardware sets so that sets win
		clr = '0;
		if (s.ap_valid && s.ap_wr) begin
			case (s.ap_sel)
				scs_pkg::RSEL_MODE:   n.mode = hwdata[7:0];
				scs_pkg::RSEL_DIV:    n.div = hwdata[7:0];
				scs_pkg::RSEL_CTRL:   n.ctrl = hwdata[7:0];
				scs_pkg::RSEL_TXBUF:  n.txbuf = hwdata[7:0];
				scs_pkg::RSEL_CARD:   n.card = hwdata[7:0] & scs_pkg::CARD_MASK;
				scs_pkg::RSEL_STATUS: clr = ~hwdata[7:0] & s.seen & scs_pkg::STS_CLR_MASK;
				default:              clr = '0;
			endcase
		end
		n.status = s.status & ~clr; // RULE19
		if (clr[scs_pkg::STS_TXE]) begin
			n.status[scs_pkg::STS_TXEND] = 1'b0;
		end
		n.seen = n.seen & ~clr;

		// Frame engine
		lb = scs_conv(s.txbuf, s.card[scs_pkg::CARD_DIR], s.card[scs_pkg::CARD_INV]);
		rdat = scs_conv(s.rxf[8:1], s.card[scs_pkg::CARD_DIR], s.card[scs_pkg::CARD_INV]);
		bad = (^s.rxf[9:1]) ^ s.mode[scs_pkg::MODE_ODD]; // RULE14
		err_now = s.err || (s.pos == scs_pkg::P_ERR_SAMPLE && !s.line_s2);
		unique case (s.state)
			scs_pkg::ST_IDLE: begin
				if (en && txen && !s.status[scs_pkg::STS_TXE]) begin
					n.state = scs_pkg::ST_TX;
					n.pos = '0;
					n.sub = '0;
					n.err = 1'b0;
					n.txf = {(^lb) ^ s.mode[scs_pkg::MODE_ODD], lb, 1'b0}; // RULE1
				end else if (en && rxen && !txen && s.line_prev && !s.line_s2) begin
					n.state = scs_pkg::ST_RX; // RULE21
					n.pos = '0;
					n.sub = '0;
					n.perr = 1'b0;
				end
			end
			scs_pkg::ST_TX: begin
				if (!en || !txen) begin
					n.state = scs_pkg::ST_IDLE;
				end else if (hstep) begin
					n.pos = s.pos + 5'd1;
					if (!s.pos[0] && s.pos < scs_pkg::P_RELEASE) begin
						n.rxf[s.pos[4:1]] = s.line_s2; // RULE7 RULE21
					end
					if (s.pos == scs_pkg::P_ERR_SAMPLE && !s.line_s2) begin
						n.err = 1'b1; // RULE4
						n.status[scs_pkg::STS_ERRSIG] = 1'b1; // RULE19
					end
					if (!err_now && s.pos == (gsm ? scs_pkg::P_TRANSMIT_END_FLAG_GSM : scs_pkg::P_TRANSMIT_END_FLAG_STD)) begin
						n.status[scs_pkg::STS_TXEND] = 1'b1; // RULE20
						n.status[scs_pkg::STS_TXE] = 1'b1; // RULE22
					end
					if (rxen && s.pos == scs_pkg::P_DELIVER) begin
						if (s.status[scs_pkg::STS_RXF]) begin
							n.status[scs_pkg::STS_OVR] = 1'b1;
						end else begin
							n.rxbuf = rdat; // RULE7
							n.status[scs_pkg::STS_RXF] = 1'b1;
							n.status[scs_pkg::STS_PAR] = s.status[scs_pkg::STS_PAR] | bad;
						end
					end
					if (s.err && s.pos == scs_pkg::P_END_RETRY) begin
						n.pos = '0; // RULE4 RULE22
						n.err = 1'b0;
					end else if (!s.err && s.pos == scs_pkg::P_END) begin
						n.state = scs_pkg::ST_IDLE; // RULE2
					end
				end
			end
			scs_pkg::ST_RX: begin
				if (!en || !rxen) begin
					n.state = scs_pkg::ST_IDLE;
				end else if (hstep) begin
					n.pos = s.pos + 5'd1;
					if (!s.pos[0] && s.pos < scs_pkg::P_RELEASE) begin
						n.rxf[s.pos[4:1]] = s.line_s2; // RULE21
					end
					if (s.pos == '0 && s.line_s2) begin
						n.state = scs_pkg::ST_IDLE;
					end
					if (s.pos == scs_pkg::P_DELIVER) begin
						n.perr = bad; // RULE3
						if (s.status[scs_pkg::STS_RXF]) begin
							n.status[scs_pkg::STS_OVR] = 1'b1;
						end else begin
							n.rxbuf = rdat;
							n.status[scs_pkg::STS_RXF] = 1'b1;
							n.status[scs_pkg::STS_PAR] = s.status[scs_pkg::STS_PAR] | bad;
						end
					end
					if (s.pos == scs_pkg::P_RX_END) begin
						n.state = scs_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				n.state = scs_pkg::ST_IDLE;
			end
		endcase

		// Open-drain data line drive
		n.data_out = 1'b0;
		n.data_oe = 1'b0;
		if (s.state == scs_pkg::ST_TX && s.pos < scs_pkg::P_RELEASE) begin
			n.data_oe = ~s.txf[s.pos[4:1]]; // RULE1 RULE5
		end else if (s.state == scs_pkg::ST_RX && s.perr &&
				(s.pos == scs_pkg::P_PULSE_A || s.pos == scs_pkg::P_PULSE_B)) begin
			n.data_oe = 1'b1; // RULE3
		end

		// Clock pin
		n.sck_oe = 1'b0;
		n.sck_out = 1'b0;
		if (en && !gsm) begin
			n.sck_oe = s.ctrl[scs_pkg::CTRL_CLK_LO]; // RULE9
			n.sck_out = s.sck;
		end else if (en) begin
			n.sck_oe = 1'b1; // RULE10
			n.sck_out = s.ctrl[scs_pkg::CTRL_CLK_LO] ? s.sck : s.ctrl[scs_pkg::CTRL_CLK_HI]; // RULE18
		end
	end

	// ========================================
	// Registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
			s.state <= scs_pkg::ST_IDLE;
			s.status <= scs_pkg::RST_STATUS;
			s.mode <= scs_pkg::RST_REG;
			s.ctrl <= scs_pkg::RST_REG;
			s.card <= scs_pkg::RST_REG;
			s.line_s1 <= 1'b1;
			s.line_s2 <= 1'b1;
			s.line_prev <= 1'b1;
			s.hready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign hrdata = s.hrdata;
	assign hreadyout = s.hready;
	assign hresp = s.hresp;
	assign serial_out_pin = s.data_out;
	assign serial_out_oe = s.data_oe;
	assign serial_clock_pin = s.sck_out;
	assign serial_clock_oe = s.sck_oe;

	// ========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_err_pulse;
		(s.state == scs_pkg::ST_RX && s.perr && s.pos == scs_pkg::P_PULSE_A)
			|=> serial_out_oe;
	endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("No error pulse"); // RULE3
	property p_release;
		(s.state == scs_pkg::ST_TX && s.pos >= scs_pkg::P_RELEASE) |=> !serial_out_oe;
	endproperty
	a_release: assert property (p_release) else $error("Line not released"); // RULE5
	property p_guard;
		(s.state == scs_pkg::ST_TX && s.pos < scs_pkg::P_END && txen && en
			&& !hstep) |=> s.state == scs_pkg::ST_TX;
	endproperty
	a_guard: assert property (p_guard) else $error("Frame ended early"); // RULE2
	property p_retry;
		(s.state == scs_pkg::ST_TX && txen && en && hstep && s.err
			&& s.pos == scs_pkg::P_END_RETRY) |=> (s.state == scs_pkg::ST_TX && s.pos == 5'd0);
	endproperty
	a_retry: assert property (p_retry) else $error("No resend after error"); // RULE4
	property p_errflag;
		(s.state == scs_pkg::ST_TX && txen && en && hstep
			&& s.pos == scs_pkg::P_ERR_SAMPLE && !s.line_s2) |=> s.status[scs_pkg::STS_ERRSIG];
	endproperty
	a_errflag: assert property (p_errflag) else $error("Error flag not set"); // RULE19
	property p_transmit_end_flag;
		(s.state == scs_pkg::ST_TX && txen && en && hstep && !gsm && !s.err
			&& s.pos == scs_pkg::P_TRANSMIT_END_FLAG_STD) |=> s.status[scs_pkg::STS_TXEND];
	endproperty
	a_transmit_end_flag: assert property (p_transmit_end_flag) else $error("End flag late"); // RULE20
	property p_sck_toggle;
		(rstn && tick) |=> (s.sck != $past(s.sck));
	endproperty
	a_sck_toggle: assert property (p_sck_toggle) else $error("Clock did not toggle"); // RULE16
	property p_clk_off;
		(!gsm && !s.ctrl[scs_pkg::CTRL_CLK_LO]) |=> !serial_clock_oe;
	endproperty
	a_clk_off: assert property (p_clk_off) else $error("Clock pin driven"); // RULE9
	property p_clk_high;
		(en && gsm && s.ctrl[1:0] == 2'b10) |=> (serial_clock_oe && serial_clock_pin);
	endproperty
	a_clk_high: assert property (p_clk_high) else $error("Clock not held high"); // RULE18

endmodule : scs_top
